// ==== rtl/pll_ctrl_pkg.sv ====
package pll_ctrl_pkg;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_INSEL    = 8'h08;
   localparam logic [7:0] ADDR_CFG_BASE = 8'h20;
   localparam logic [7:0] ADDR_CFG_LAST = 8'h3c;

   // Configuration word count and indices
   localparam int       CFG_WORDS   = 8;
   localparam logic [2:0] CFG_LOOPBW  = 3'h0;
   localparam logic [2:0] CFG_FASTBW  = 3'h1;
   localparam logic [2:0] CFG_INDIV   = 3'h2;
   localparam logic [2:0] CFG_FBDIV   = 3'h3;
   localparam logic [2:0] CFG_FRACDIV = 3'h4;
   localparam logic [2:0] CFG_XPT     = 3'h5;
   localparam logic [2:0] CFG_RDIV0   = 3'h6;
   localparam logic [2:0] CFG_RDIV1   = 3'h7;
   localparam logic [2:0] CFG_LAST    = 3'h7;

   // Control register bit positions
   localparam int CTRL_HARD  = 0;
   localparam int CTRL_SOFT  = 1;
   localparam int CTRL_FAST  = 2;
   localparam int CTRL_AUTO  = 3;
   localparam int CTRL_STORE = 4;

   // Bandwidth codes: 0 is 0.1 Hz, 15 is 4 kHz, 6 is 100 Hz
   localparam logic [4:0] BW_MAX_CODE     = 5'h0f;
   localparam logic [4:0] LOOPBW_MIN_CODE = 5'h00;
   localparam logic [4:0] FASTBW_MIN_CODE = 5'h06;

   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   // Reset values of control fields
   localparam logic       RST_FAST   = 1'b0;
   localparam logic       RST_AUTO   = 1'b0;
   localparam logic [1:0] RST_MANSEL = 2'h0;

   // PLL modes, Gray along free-run, acquire, locked, holdover
   typedef enum logic [1:0] {
      MODE_FREERUN  = 2'h0,
      MODE_ACQUIRE  = 2'h1,
      MODE_LOCKED   = 2'h3,
      MODE_HOLDOVER = 2'h2
   } mode_t;

   // Nonvolatile sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'h0,
      SEQ_LOAD  = 2'h1,
      SEQ_STORE = 2'h3
   } seq_t;

   // Factory contents of unprogrammed nonvolatile words
   function automatic logic [31:0] factoryWord(input logic [2:0] idx);
      case (idx)
         CFG_LOOPBW:  factoryWord = 32'h0000_0004;
         CFG_FASTBW:  factoryWord = 32'h0000_000a;
         CFG_XPT:     factoryWord = 32'h0000_0004;
         default:     factoryWord = 32'h0000_0001;
      endcase
   endfunction : factoryWord

   // Keep a bandwidth code inside its legal span
   function automatic logic [4:0] clampBw(input logic [31:0] w,
                                          input logic [4:0]  lo);
      if (w > {27'h0, BW_MAX_CODE})
         clampBw = BW_MAX_CODE;
      else if (w[4:0] < lo)
         clampBw = lo;
      else
         clampBw = w[4:0];
   endfunction : clampBw

endpackage : pll_ctrl_pkg

// ==== rtl/nvm_port_if.sv ====
`timescale 1ns/10ps
interface nvm_port_if;
   logic        rdEn;    // Read request
   logic        wrEn;    // Program request
   logic [2:0]  addr;    // Word index
   logic [31:0] wrData;  // Word to program
   logic [31:0] rdData;  // Registered read word

   modport ctrl (output rdEn, output wrEn, output addr, output wrData,
                 input rdData);
   modport mem  (input rdEn, input wrEn, input addr, input wrData,
                 output rdData);
endinterface : nvm_port_if

// ==== rtl/nvm_store.sv ====
`timescale 1ns/10ps
module nvm_store
   import pll_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   nvm_port_if.mem  port
);

   logic [31:0]          mem [CFG_WORDS];  // Programmed words
   logic [CFG_WORDS-1:0] written;          // Word has been programmed
   logic [CFG_WORDS-1:0] next_written;
   logic [31:0]          rdWord;           // Read data register
   logic [31:0]          next_rdWord;

   ////////////////////////////////////////////////////////////////////
   // Only power-on clears the programmed map; device resets keep it
   always_comb begin
      next_written = written;
      next_rdWord  = rdWord;
      if (port.wrEn) begin
         next_written[port.addr] = 1'b1;
      end
      if (port.rdEn) begin
         next_rdWord = written[port.addr] ? mem[port.addr]
                                          : factoryWord(port.addr);
      end
   end

   // Map and read register
   always_ff @(posedge clk) begin
      if (rst) begin
         written <= '0;
         rdWord  <= '0;
      end else begin
         written <= next_written;
         rdWord  <= next_rdWord;
      end
   end

   // Array itself has no reset, as a real store would not
   always_ff @(posedge clk) begin
      if (port.wrEn) begin
         mem[port.addr] <= port.wrData;
      end
   end

   assign port.rdData = rdWord;

endmodule : nvm_store

// ==== rtl/ref_select.sv ====
`timescale 1ns/10ps
module ref_select
   import pll_ctrl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [3:0] inputValid,
   input  wire logic       autoMode,
   input  wire logic [1:0] manualSel,
   output logic      [1:0] selInput,
   output logic            selValid
);

   logic [1:0] next_selInput;  // Chosen reference
   logic       next_selValid;  // Chosen reference is usable

   ////////////////////////////////////////////////////////////////////
   // Auto keeps a still valid input to avoid needless switching
   always_comb begin
      next_selInput = selInput;
      if (!autoMode) begin
         next_selInput = manualSel;
      end else if (!inputValid[selInput]) begin
         for (int i = 3; i >= 0; i--) begin
            if (inputValid[i]) begin
               next_selInput = 2'(i);
            end
         end
      end
      next_selValid = inputValid[next_selInput];
   end

   // Selection registers
   always_ff @(posedge clk) begin
      if (rst) begin
         selInput <= RST_MANSEL;
         selValid <= 1'b0;
      end else begin
         selInput <= next_selInput;
         selValid <= next_selValid;
      end
   end

endmodule : ref_select

// ==== rtl/pll_mode_ctrl.sv ====
// Notes on behaviour
// - Power-up loads registers from nonvolatile store
// - No bus access before initialization ends
// - Output clocks stay off during initialization
// - Hard reset reloads store, resets everything
// - Hard reset by pin or control bit
// - Soft reset only applies written configuration
// - Exactly one of four modes once initialized
// - Loop bandwidth code spans 0.1 Hz-4 kHz
// - Fastlock bandwidth used while acquiring lock
// - Normal bandwidth restored once lock achieved
// - Reference chosen manually or automatically
// - Frequency plan writable and storable
// - Crosspoint source plus integer divider per output
// - Free-run entered right after initialization
// - Valid input starts lock acquisition
// - Holdover when selected input lost while locked, none else
// - Valid input in holdover restarts acquisition
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module pll_mode_ctrl
   import pll_ctrl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        extResetN,
   input  wire logic [3:0]  inputValid,
   input  wire logic        pllLockDet,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   output logic [1:0]       clkOutEnable,
   output logic [4:0]       loopBwCode,
   output logic [1:0]       pllMode,
   output logic [1:0]       refSelect,
   output logic [31:0]      inDiv,
   output logic [31:0]      fbDiv,
   output logic [31:0]      fracDiv,
   output logic [1:0]       outSrc0,
   output logic [1:0]       outSrc1,
   output logic [31:0]      outDiv0,
   output logic [31:0]      outDiv1
);

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic        hardReq;        // Any hard reset source this cycle
   logic        hardPulse;      // Hard reset bit written
   logic        softPulse;      // Soft reset bit written
   logic        storePulse;     // Store command written
   logic        ctrlFast;       // Fastlock enable
   logic        ctrlAuto;       // Automatic reference choice
   logic [1:0]  manSel;         // Manual reference number
   logic        dpWrite;        // Write data phase pending
   logic [7:0]  dpAddr;         // Data phase address
   logic        next_hardPulse, next_softPulse, next_storePulse;
   logic        next_ctrlFast, next_ctrlAuto, next_dpWrite;
   logic [1:0]  next_manSel;
   logic [7:0]  next_dpAddr;
   logic [31:0] next_hrdata;
   logic        addrTaken;      // Address phase accepted
   logic        cfgHit;         // Data phase hits config window
   logic [2:0]  cfgIdx;         // Config word of data phase

   seq_t        seq;            // Store sequencer state
   seq_t        next_seq;
   logic [3:0]  ptr;            // Word pointer for load/store
   logic [3:0]  next_ptr;
   logic        capValid;       // Read word arrives this cycle
   logic        next_capValid;
   logic [2:0]  capIdx;         // Index of arriving word
   logic [2:0]  next_capIdx;
   logic        initDone;       // Initialization finished
   logic        next_initDone;
   logic [31:0] cfg    [CFG_WORDS];  // Software-visible words
   logic [31:0] active [CFG_WORDS];  // Words in effect
   logic [31:0] next_cfg    [CFG_WORDS];
   logic [31:0] next_active [CFG_WORDS];

   mode_t       mode;           // Current PLL mode
   mode_t       next_mode;
   logic [4:0]  next_loopBwCode;
   logic [1:0]  next_clkOutEnable;
   logic        selValid;       // Chosen reference usable
   logic        pllLocked;      // Alias of lock detector

   nvm_port_if  nvm ();

   ////////////////////////////////////////////////////////////////////
   // Submodules
   nvm_store u_store (
      .clk  (clk),
      .rst  (rst),
      .port (nvm.mem)
   );

   ref_select u_sel (
      .clk        (clk),
      .rst        (hardReq),
      .inputValid (inputValid),
      .autoMode   (ctrlAuto),
      .manualSel  (manSel),
      .selInput   (refSelect),
      .selValid   (selValid)
   );

   assign hardReq   = rst | ~extResetN | hardPulse;
   assign pllLocked = pllLockDet;

   ////////////////////////////////////////////////////////////////////
   // Bus slave
   // no access before init
   // Gate on initDone too, so a foreign hready cannot sneak in early
   assign addrTaken = hsel & hready & initDone &
                      (htrans == HTRANS_NONSEQ);
   assign cfgHit    = (dpAddr >= ADDR_CFG_BASE) &&
                      (dpAddr <= ADDR_CFG_LAST);
   assign cfgIdx    = dpAddr[4:2];
   assign hreadyout = initDone;
   assign hresp     = HRESP_OKAY;

   // Decode, register read data at the address phase
   always_comb begin
      next_hardPulse  = 1'b0;
      next_softPulse  = 1'b0;
      next_storePulse = 1'b0;
      next_ctrlFast   = ctrlFast;
      next_ctrlAuto   = ctrlAuto;
      next_manSel     = manSel;
      next_dpWrite    = addrTaken & hwrite;
      next_dpAddr     = addrTaken ? haddr[7:0] : dpAddr;
      next_hrdata     = hrdata;
      if (dpWrite && dpAddr == ADDR_CTRL) begin
         next_hardPulse  = hwdata[CTRL_HARD];
         next_softPulse  = hwdata[CTRL_SOFT];
         next_storePulse = hwdata[CTRL_STORE];
         next_ctrlFast   = hwdata[CTRL_FAST];
         next_ctrlAuto   = hwdata[CTRL_AUTO];
      end
      if (dpWrite && dpAddr == ADDR_INSEL) begin
         next_manSel = hwdata[1:0];
      end
      if (addrTaken && !hwrite) begin
         // Unmapped words read as zero
         next_hrdata = '0;
         case (haddr[7:0])
            ADDR_CTRL:
               next_hrdata = {27'h0, 1'b0, ctrlAuto, ctrlFast, 2'h0};
            ADDR_STATUS:
               next_hrdata = {25'h0, (seq != SEQ_IDLE), selValid,
                              refSelect, mode, initDone};
            ADDR_INSEL:
               next_hrdata = {30'h0, manSel};
            default:
               if (haddr[7:0] >= ADDR_CFG_BASE &&
                   haddr[7:0] <= ADDR_CFG_LAST &&
                   haddr[1:0] == 2'h0) begin
                  next_hrdata = cfg[haddr[4:2]];
               end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (hardReq) begin
         hardPulse  <= 1'b0;
         softPulse  <= 1'b0;
         storePulse <= 1'b0;
         ctrlFast   <= RST_FAST;
         ctrlAuto   <= RST_AUTO;
         manSel     <= RST_MANSEL;
         dpWrite    <= 1'b0;
         dpAddr     <= '0;
         hrdata     <= '0;
      end else begin
         hardPulse  <= next_hardPulse;
         softPulse  <= next_softPulse;
         storePulse <= next_storePulse;
         ctrlFast   <= next_ctrlFast;
         ctrlAuto   <= next_ctrlAuto;
         manSel     <= next_manSel;
         dpWrite    <= next_dpWrite;
         dpAddr     <= next_dpAddr;
         hrdata     <= next_hrdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Nonvolatile load and store sequencer
   assign nvm.rdEn   = (seq == SEQ_LOAD) && (ptr < 4'(CFG_WORDS));
   assign nvm.wrEn   = (seq == SEQ_STORE);
   assign nvm.addr   = ptr[2:0];
   assign nvm.wrData = cfg[ptr[2:0]];

   // Load words, apply soft reset, program frequency plan
   always_comb begin
      next_seq      = seq;
      next_ptr      = ptr;
      next_initDone = initDone;
      next_capValid = nvm.rdEn;
      next_capIdx   = ptr[2:0];
      next_cfg      = cfg;
      next_active   = active;
      case (seq)
         SEQ_LOAD: begin
            if (nvm.rdEn) begin
               next_ptr = ptr + 4'h1;
            end
            if (capValid) begin
               next_cfg[capIdx]    = nvm.rdData;
               next_active[capIdx] = nvm.rdData;
               if (capIdx == CFG_LAST) begin
                  next_seq      = SEQ_IDLE;
                  next_initDone = 1'b1;
               end
            end
         end
         SEQ_STORE: begin
            next_ptr = ptr + 4'h1;
            if (ptr[2:0] == CFG_LAST) begin
               next_seq = SEQ_IDLE;
            end
         end
         SEQ_IDLE: begin
            if (storePulse) begin
               next_seq = SEQ_STORE;
               next_ptr = '0;
            end
         end
         default: next_seq = SEQ_IDLE;
      endcase
      if (dpWrite && cfgHit) begin
         next_cfg[cfgIdx] = hwdata;
      end
      if (softPulse) begin
         next_active = cfg;
      end
   end

   always_ff @(posedge clk) begin
      if (hardReq) begin
         seq      <= SEQ_LOAD;
         ptr      <= '0;
         capValid <= 1'b0;
         capIdx   <= '0;
         initDone <= 1'b0;
      end else begin
         seq      <= next_seq;
         ptr      <= next_ptr;
         capValid <= next_capValid;
         capIdx   <= next_capIdx;
         initDone <= next_initDone;
      end
   end

   // Word registers, overwritten by the load that follows reset
   always_ff @(posedge clk) begin
      if (hardReq) begin
         for (int i = 0; i < CFG_WORDS; i++) begin
            cfg[i]    <= '0;
            active[i] <= '0;
         end
      end else begin
         cfg    <= next_cfg;
         active <= next_active;
      end
   end

   assign outSrc0 = active[CFG_XPT][1:0];
   assign outSrc1 = active[CFG_XPT][3:2];
   assign outDiv0 = active[CFG_RDIV0];
   assign outDiv1 = active[CFG_RDIV1];
   assign inDiv   = active[CFG_INDIV];
   assign fbDiv   = active[CFG_FBDIV];
   assign fracDiv = active[CFG_FRACDIV];

   ////////////////////////////////////////////////////////////////////
   // PLL mode machine and bandwidth choice
   always_comb begin
      next_mode = mode;
      case (mode)
         MODE_FREERUN: begin
            if (selValid) next_mode = MODE_ACQUIRE;
         end
         MODE_ACQUIRE: begin
            if (!selValid)      next_mode = MODE_FREERUN;
            else if (pllLocked) next_mode = MODE_LOCKED;
         end
         MODE_LOCKED: begin
            if (!selValid)       next_mode = MODE_HOLDOVER;
            else if (!pllLocked) next_mode = MODE_ACQUIRE;
         end
         MODE_HOLDOVER: begin
            if (selValid) next_mode = MODE_ACQUIRE;
         end
         default: next_mode = MODE_FREERUN;
      endcase
      if (!initDone) next_mode = MODE_FREERUN;
      next_loopBwCode = clampBw(active[CFG_LOOPBW], LOOPBW_MIN_CODE);
      if (mode == MODE_ACQUIRE && ctrlFast) begin
         next_loopBwCode = clampBw(active[CFG_FASTBW], FASTBW_MIN_CODE);
      end
      next_clkOutEnable = {2{initDone}};
   end

   always_ff @(posedge clk) begin
      if (hardReq) begin
         mode         <= MODE_FREERUN;
         loopBwCode   <= LOOPBW_MIN_CODE;
         clkOutEnable <= '0;
      end else begin
         mode         <= next_mode;
         loopBwCode   <= next_loopBwCode;
         clkOutEnable <= next_clkOutEnable;
      end
   end

   assign pllMode = mode;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_reset_released;
      $fell(hardReq) ##1 (!hardReq) [*8];
   endsequence

   a_clocks_off_init: assert property (
      !initDone |-> clkOutEnable == 2'h0)
      else $error("output clock enabled before init");
   a_bus_stall_init: assert property (
      !initDone |-> !hreadyout && !dpWrite)
      else $error("bus ready before init");
   a_hard_reload: assert property (
      hardReq |=> !initDone && seq == SEQ_LOAD)
      else $error("hard reset did not restart load");
   a_init_bounded: assert property (
      s_reset_released |-> ##[0:2] initDone)
      else $error("init load too slow");
   a_freerun_first: assert property (
      $rose(initDone) |-> mode == MODE_FREERUN)
      else $error("init left pll outside free-run");
   a_acquire_start: assert property (
      !hardReq && initDone && mode == MODE_FREERUN && selValid
      |=> mode == MODE_ACQUIRE)
      else $error("valid input did not start acquisition");
   a_holdover_entry: assert property (
      !hardReq && mode == MODE_LOCKED && !selValid
      |=> mode == MODE_HOLDOVER)
      else $error("lost input did not give holdover");
   a_holdover_exit: assert property (
      !hardReq && mode == MODE_HOLDOVER && selValid
      |=> mode == MODE_ACQUIRE)
      else $error("holdover not left on valid input");
   a_fast_bw_used: assert property (
      !hardReq && mode == MODE_ACQUIRE && ctrlFast |=>
      loopBwCode == clampBw($past(active[CFG_FASTBW]), FASTBW_MIN_CODE))
      else $error("fastlock bandwidth not applied");
   a_normal_bw_back: assert property (
      !hardReq && mode == MODE_LOCKED |=>
      loopBwCode == clampBw($past(active[CFG_LOOPBW]), LOOPBW_MIN_CODE))
      else $error("loop bandwidth not restored");
   a_soft_apply: assert property (
      !hardReq && softPulse |=> inDiv == $past(cfg[CFG_INDIV]) && initDone)
      else $error("soft reset did not apply config");

endmodule : pll_mode_ctrl

// ==== testbench/pll_lock_model.sv ====
`timescale 1ns/10ps
module pll_lock_model
   import pll_ctrl_pkg::*;
#(
   parameter int LOCK_DELAY = 8        // Pull-in cycles before lock
)
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] pllMode,
   input  wire logic       dropLock,
   output logic            pllLockDet
);
   int lockCount;                      // Cycles spent pulling in

   ////////////////////////////////////////////////////////////////////
   // Lock detector: needs a steady pull-in, never lies without a ref
   // lock after pull-in
   always_ff @(posedge clk) begin
      if (rst || dropLock || pllMode == MODE_FREERUN ||
          pllMode == MODE_HOLDOVER) begin
         // No reference, so lock is gone at once
         lockCount  <= 0;
         pllLockDet <= 1'b0;
      end else if (lockCount < LOCK_DELAY) begin
         lockCount  <= lockCount + 1;
      end else begin
         pllLockDet <= 1'b1;
      end
   end
endmodule : pll_lock_model

// ==== testbench/pll_mode_ctrl_bench.sv ====
`timescale 1ns/10ps
module pll_mode_ctrl_bench
   import pll_ctrl_pkg::*;
;
   logic        clk, rst, extResetN, pllLockDet, dropLock;
   logic [3:0]  inputValid;
   logic        hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, inDiv, fbDiv, fracDiv;
   logic [31:0] outDiv0, outDiv1;
   logic [1:0]  htrans, clkOutEnable, pllMode, refSelect;
   logic [1:0]  outSrc0, outSrc1;
   logic [2:0]  hsize;
   logic [4:0]  loopBwCode;
   int          miscompares;           // Failed comparisons
   int          totalChecks;           // All comparisons

   pll_mode_ctrl u_pll_mode_ctrl (.clk(clk), .rst(rst),
      .extResetN(extResetN), .inputValid(inputValid),
      .pllLockDet(pllLockDet), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .clkOutEnable(clkOutEnable),
      .loopBwCode(loopBwCode), .pllMode(pllMode), .refSelect(refSelect),
      .inDiv(inDiv), .fbDiv(fbDiv), .fracDiv(fracDiv), .outSrc0(outSrc0),
      .outSrc1(outSrc1), .outDiv0(outDiv0), .outDiv1(outDiv1));

   pll_lock_model u_pll_lock_model (.clk(clk), .rst(rst),
      .pllMode(pllMode), .dropLock(dropLock), .pllLockDet(pllLockDet));

   ////////////////////////////////////////////////////////////////////
   // Clock, 100 ns period
   always #50 clk = ~clk;

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One AHB single transfer; waits out the init stall
   task automatic xfer(input logic [7:0] a, input logic wr,
                       input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(a, 1'b0, 32'h0, q);
      chk(q, exp);
   endtask : rd

   // Bounded wait for a mode, then compare it
   task automatic waitMode(input logic [1:0] m);
      int n;
      n = 0;
      while (pllMode !== m && n < 14) begin
         @(posedge clk);
         n++;
      end
      chk({30'h0, pllMode}, {30'h0, m});
   endtask : waitMode

   task wrap_up;
      if (miscompares == 0 && totalChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////
   // Watchdog: the whole run is well under a thousand cycles
   initial begin
      repeat (4000) @(posedge clk);
      miscompares++;
      wrap_up();
   end

   initial begin
      clk = 0; rst = 1; extResetN = 1; inputValid = 0; dropLock = 0;
      hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0; hwdata = 0;
      miscompares = 0; totalChecks = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      chk({30'h0, clkOutEnable}, 32'h0);
      chk({31'h0, hreadyout}, 32'h0);
      rd(ADDR_STATUS, 32'h1);
      chk({30'h0, clkOutEnable}, 32'h3);
      rd(ADDR_CFG_BASE, 32'h4);
      chk({27'h0, loopBwCode}, 32'h4);
      // Plan words only go live on soft reset
      for (int i = 2; i < 8; i++) begin
         wr(ADDR_CFG_BASE + 8'(4 * i), 32'h10 + 32'(i));
      end
      chk(inDiv, 32'h1);
      wr(ADDR_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      chk(inDiv, 32'h12);
      chk(fbDiv, 32'h13);
      chk(fracDiv, 32'h14);
      chk({28'h0, outSrc1, outSrc0}, 32'h5);
      chk(outDiv0, 32'h16);
      chk(outDiv1, 32'h17);
      rd(8'h80, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      // Hard reset by bit drops the live plan
      wr(ADDR_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk({30'h0, clkOutEnable}, 32'h0);
      chk({31'h0, hreadyout}, 32'h0);
      rd(ADDR_STATUS, 32'h1);
      chk(inDiv, 32'h1);
      // Stored word must survive a pin reset
      wr(ADDR_CFG_BASE + 8'h8, 32'h22);
      wr(ADDR_CTRL, 32'h10);
      // Store busy shows while programming runs
      @(posedge clk);
      rd(ADDR_STATUS, 32'h41);
      repeat (8) @(posedge clk);
      extResetN <= 1'b0;
      @(posedge clk);
      extResetN <= 1'b1;
      @(posedge clk);
      rd(ADDR_STATUS, 32'h1);
      chk(inDiv, 32'h22);
      // Fastlock code below its floor, clamped while acquiring
      wr(ADDR_CFG_BASE + 8'h4, 32'h2);
      wr(ADDR_CTRL, 32'he);
      rd(ADDR_CTRL, 32'hc);
      inputValid <= 4'b0010;
      waitMode(MODE_ACQUIRE);
      repeat (2) @(posedge clk);
      chk({27'h0, loopBwCode}, 32'h6);
      chk({30'h0, refSelect}, 32'h1);
      waitMode(MODE_LOCKED);
      repeat (2) @(posedge clk);
      chk({27'h0, loopBwCode}, 32'h4);
      rd(ADDR_STATUS, 32'h2f);
      inputValid <= 4'b0000;
      waitMode(MODE_HOLDOVER);
      inputValid <= 4'b0100;
      waitMode(MODE_ACQUIRE);
      chk({30'h0, refSelect}, 32'h2);
      waitMode(MODE_LOCKED);
      dropLock <= 1'b1;
      waitMode(MODE_ACQUIRE);
      // Manual pick of a dead input falls back to free-run
      wr(ADDR_INSEL, 32'h3);
      rd(ADDR_INSEL, 32'h3);
      wr(ADDR_CTRL, 32'h0);
      waitMode(MODE_FREERUN);
      inputValid <= 4'b1000;
      waitMode(MODE_ACQUIRE);
      chk({30'h0, refSelect}, 32'h3);
      wrap_up();
   end
endmodule : pll_mode_ctrl_bench
